// ==== rxs_top.sv ====
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - Power-on: reset, pin low 4096 cycles
// - Then 64 more cycles before CPU release
// - Clock output on, CPU clocks held 4096
// - Power-on sets its flag, clears others
// - Watchdog overflow resets unless disabled
// - Illegal instruction sets flag and resets
// - Stop disallowed acts as illegal opcode
// - Unmapped opcode fetch resets, flag set
// - Unmapped data access never resets
// - Brown-out resets unless either disable set
// - Brown-out: 4096 after recovery, then 64
// - 12-bit counter on reference falling edge
// - Counter overflow clocks the watchdog
// - Stop clears counter; wake 32 or 4096
// - Pin reset spares counter; free-running after
// - Latched interrupt holds until serviced/masked
// - Interrupts at instruction end, unmasked, enabled
// - Highest priority first; pending retaken at return
// - Entry sets mask; return restores state
// - Soft trap ignores mask, stacks current PC
// - Resets override all interrupts
// - Break request forces soft-trap vector
// - Internal reset: pin low 32, then 32
// - Internal reset clears counter
// - Reading cause register clears it
module rxs_top
  import rxs_pkg::*;
#(
  parameter int LONG_CNT = RXS_LONG_CNT
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                osc_ref_clock,
  input  wire logic                power_on_pulse,
  input  wire logic                brownout,
  input  wire logic                pin_reset_in_n,
  input  wire logic                break_req,
  input  wire rxs_cpu_s            cpu,
  input  wire logic [RXS_NIRQ-1:0] irq_req,
  output logic                     internal_reset,
  output logic                     pin_reset_out,
  output logic                     pin_reset_oe,
  output logic                     clock_gen_output,
  output logic                     cpu_clk_en,
  output logic                     watchdog_tick,
  output rxs_exc_s                 exc,
  output logic                     stack_pc_minus1,
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  // ==========================================================
  // Reference clock sampling (inputs treated synchronous)
  logic                  ref_d_r;
  logic                  ref_fall;
  logic [RXS_CNT_W-1:0]  cnt_r;
  logic                  cnt_ovf;
  rxs_state_e            state_r;
  logic [12:0]           phase_r;
  logic                  is_long_r;
  logic [7:0]            cause_r;
  logic [4:0]            cfg_r;
  logic [RXS_NIRQ-1:0]   irq_en_r;
  logic                  wdg_ovf;
  logic                  rst_opc;
  logic                  rst_fet;
  logic                  rst_brn;
  logic                  int_src;
  logic                  cause_rd;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      ref_d_r <= 1'b0;
    else
      ref_d_r <= osc_ref_clock;

  assign ref_fall = ref_d_r & ~osc_ref_clock;

  // ==========================================================
  // Reset source decode
  localparam logic [12:0] LONG_END  = 13'(LONG_CNT);
  localparam logic [12:0] TAIL_END  = 13'(RXS_TAIL_CNT);
  localparam logic [12:0] SHORT_END = 13'(RXS_SHORT_CNT);
  localparam logic [RXS_CNT_W-1:0] CNT_MAX = {RXS_CNT_W{1'b1}};

  assign cnt_ovf = ref_fall && (cnt_r == CNT_MAX);
  assign watchdog_tick = cnt_ovf;
  // Watchdog counter driven by prescaler overflow, wrap past FF is timeout
  logic [7:0] wdg_r;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      wdg_r <= 8'h00;
    else if (internal_reset || cfg_r[RXS_C_WDIS])
      wdg_r <= 8'h00;
    else if (cnt_ovf)
      wdg_r <= wdg_r + 8'h01;

  assign wdg_ovf = cnt_ovf && (wdg_r == 8'hFF) && !cfg_r[RXS_C_WDIS];
  assign rst_opc = cpu.bad_opcode || (cpu.stop_exec && !cfg_r[RXS_C_STOP]);
  // Data accesses to holes are ignored on purpose
  assign rst_fet = cpu.opcode_fetch && cpu.unmapped;
  assign rst_brn = brownout && !cfg_r[RXS_C_BPO] && !cfg_r[RXS_C_BRO];
  assign int_src = (state_r == RXS_RUN || state_r == RXS_STOP) &&
                   (wdg_ovf || rst_opc || rst_fet);

  // ==========================================================
  // Sequencer, phase counts reference falling edges
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      state_r   <= RXS_LONG;
      phase_r   <= 13'h0000;
      is_long_r <= 1'b1;
    end
    else if (power_on_pulse || rst_brn)
    begin
      state_r   <= RXS_LONG;
      phase_r   <= 13'h0000;
      is_long_r <= 1'b1;
    end
    else if (int_src)
    begin
      state_r   <= RXS_PINLO;
      phase_r   <= 13'h0000;
      is_long_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        RXS_RUN:
          if (cpu.stop_exec && cfg_r[RXS_C_STOP])
          begin
            state_r <= RXS_STOP;
            phase_r <= 13'h0000;
          end
        RXS_LONG:
          if (ref_fall)
          begin
            if (phase_r == LONG_END - 13'h0001)
            begin
              state_r <= RXS_TAIL;
              phase_r <= 13'h0000;
            end
            else
              phase_r <= phase_r + 13'h0001;
          end
        RXS_PINLO:
          if (ref_fall)
          begin
            if (phase_r == SHORT_END - 13'h0001)
            begin
              state_r <= RXS_TAIL;
              phase_r <= TAIL_END - SHORT_END;
            end
            else
              phase_r <= phase_r + 13'h0001;
          end
        RXS_TAIL:
          if (ref_fall)
          begin
            if (phase_r == TAIL_END - 13'h0001)
              state_r <= RXS_RUN;
            else
              phase_r <= phase_r + 13'h0001;
          end
        RXS_STOP:
          // Wake on interrupt or break; pending requests end stop
          if (ref_fall && (|(irq_req & irq_en_r) || break_req || phase_r != 13'h0000))
          begin
            if (phase_r == (cfg_r[RXS_C_SHRT] ? SHORT_END : LONG_END) - 13'h0001)
            begin
              state_r <= RXS_RUN;
              phase_r <= 13'h0000;
            end
            else
              phase_r <= phase_r + 13'h0001;
          end
        default:
          state_r <= RXS_LONG;
      endcase
    end

  // ==========================================================
  // 12-bit system counter
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      cnt_r <= '0;
    else if (power_on_pulse || rst_brn || int_src)
      cnt_r <= '0;
    else if (state_r == RXS_STOP && phase_r == 13'h0000 &&
             !(|(irq_req & irq_en_r) || break_req))
      cnt_r <= '0;
    else if (ref_fall)
      cnt_r <= cnt_r + 1'b1;

  assign internal_reset   = (state_r != RXS_RUN) && (state_r != RXS_STOP);
  assign pin_reset_oe     = (state_r == RXS_LONG) || (state_r == RXS_PINLO);
  assign pin_reset_out    = 1'b0;
  assign clock_gen_output = 1'b1;
  assign cpu_clk_en       = (state_r != RXS_LONG) && (state_r != RXS_STOP);

  // ==========================================================
  // Reset cause register
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      cause_r <= 8'h00;
    else if (power_on_pulse)
      cause_r <= 8'h01 << RXS_B_POR;
    else if (rst_brn)
      cause_r <= 8'h01 << RXS_B_BRN;
    else if (int_src)
      cause_r <= wdg_ovf ? (8'h01 << RXS_B_WDG) :
                 rst_opc ? (8'h01 << RXS_B_OPC) : (8'h01 << RXS_B_FET);
    else if (!pin_reset_in_n && !pin_reset_oe && state_r == RXS_RUN)
      cause_r <= 8'h01 << RXS_B_PIN;
    else if (cause_rd)
      cause_r <= 8'h00;

  // ==========================================================
  // Interrupt arbitration
  logic [RXS_NIRQ-1:0] lat_r;
  logic                lat_v_r;
  logic [2:0]          lat_idx_r;
  logic                svc_r;

  function automatic logic [2:0] rxs_prio(input logic [RXS_NIRQ-1:0] req);
    rxs_prio = 3'h0;
    for (int i = RXS_NIRQ - 1; i >= 0; i--)
      if (req[i])
        rxs_prio = 3'(i);
  endfunction : rxs_prio

  assign lat_r = irq_req & irq_en_r;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      lat_v_r   <= 1'b0;
      lat_idx_r <= 3'h0;
    end
    else if (internal_reset || cpu.mask_i)
      lat_v_r <= 1'b0;
    else if (!lat_v_r && |lat_r)
    begin
      lat_v_r   <= 1'b1;
      lat_idx_r <= rxs_prio(lat_r);
    end
    else if (exc.take && !exc.trap_vec)
      lat_v_r <= 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      svc_r <= 1'b0;
    else if (internal_reset)
      svc_r <= 1'b0;
    else if (exc.take)
      svc_r <= 1'b1;
    else if (cpu.trap_return)
      svc_r <= 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      exc             <= '0;
      stack_pc_minus1 <= 1'b0;
    end
    else
    begin
      exc.take <= 1'b0;
      if (!internal_reset && cpu.instr_done)
      begin
        if (break_req || cpu.soft_trap)
        begin
          exc.take        <= 1'b1;
          exc.trap_vec    <= 1'b1;
          stack_pc_minus1 <= 1'b0;
        end
        else if (lat_v_r && !cpu.mask_i)
        begin
          exc.take        <= 1'b1;
          exc.trap_vec    <= 1'b0;
          exc.vec_idx     <= lat_idx_r;
          stack_pc_minus1 <= 1'b1;
        end
      end
    end

  // ==========================================================
  // AXI4-Lite slave
  logic       aw_h_r;
  logic       w_h_r;
  logic [3:0] awa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;

  assign s_axi_awready = !aw_h_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_h_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign cause_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == RXS_ADDR_CAUSE;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
      awa_r  <= 4'h0;
      wd_r   <= 32'h0000_0000;
      ws_r   <= 4'h0;
    end
    else if (aw_h_r && w_h_r)
    begin
      aw_h_r <= 1'b0;
      w_h_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_h_r <= 1'b1;
        awa_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_h_r <= 1'b1;
        wd_r  <= s_axi_wdata;
        ws_r  <= s_axi_wstrb;
      end
    end

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      cfg_r        <= RXS_CFG_RST;
      irq_en_r     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RXS_RESP_OK;
    end
    else if (aw_h_r && w_h_r)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RXS_RESP_OK;
      if (awa_r == RXS_ADDR_CFG && ws_r[0])
        cfg_r <= wd_r[4:0];
      else if (awa_r == RXS_ADDR_IRQEN && ws_r[0])
        irq_en_r <= wd_r[RXS_NIRQ-1:0];
      else if (awa_r != RXS_ADDR_CFG && awa_r != RXS_ADDR_IRQEN)
        s_axi_bresp <= RXS_RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RXS_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RXS_RESP_OK;
      case (s_axi_araddr)
        RXS_ADDR_CAUSE: s_axi_rdata <= {24'h000000, cause_r};
        RXS_ADDR_CFG:   s_axi_rdata <= {27'h0000000, cfg_r};
        RXS_ADDR_STAT:  s_axi_rdata <= {14'h0000, state_r, cnt_r, lat_v_r};
        RXS_ADDR_IRQEN: s_axi_rdata <= {24'h000000, irq_en_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RXS_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ==========================================================
  // Checks
  sequence s_pin_phase;
    state_r == RXS_PINLO;
  endsequence

  a_src_pinlow: assert property (@(posedge clk_sys) disable iff (rst)
    int_src && !power_on_pulse && !rst_brn |=> s_pin_phase)
    else $error("internal source did not drive pin low");
  a_data_noreset: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == RXS_RUN && cpu.unmapped && !cpu.opcode_fetch && !wdg_ovf && !rst_opc
      && !power_on_pulse && !rst_brn |=> state_r != RXS_PINLO)
    else $error("data access to hole caused reset");
  a_por_cause: assert property (@(posedge clk_sys) disable iff (rst)
    power_on_pulse |=> cause_r == (8'h01 << RXS_B_POR))
    else $error("power-on cause wrong");
  a_rd_clear: assert property (@(posedge clk_sys) disable iff (rst)
    cause_rd && !power_on_pulse && !rst_brn && !int_src && pin_reset_in_n
      |=> cause_r == 8'h00)
    else $error("cause read did not clear");
  a_reset_noint: assert property (@(posedge clk_sys) disable iff (rst)
    internal_reset |=> !exc.take)
    else $error("exception taken during reset");
  a_trap_nomask: assert property (@(posedge clk_sys) disable iff (rst)
    cpu.instr_done && cpu.soft_trap && !internal_reset |=> exc.take && exc.trap_vec
      && !stack_pc_minus1)
    else $error("soft trap not taken");
  a_mask_block: assert property (@(posedge clk_sys) disable iff (rst)
    exc.take && !exc.trap_vec |-> $past(!cpu.mask_i))
    else $error("hardware interrupt taken while masked");
  a_wdg_disable: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_r[RXS_C_WDIS] |-> !wdg_ovf)
    else $error("watchdog reset while disabled");
  a_cpu_hold: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == RXS_LONG |-> pin_reset_oe && internal_reset && !cpu_clk_en)
    else $error("long hold outputs wrong");
endmodule : rxs_top

// ==== rxs_pkg.sv ====
package rxs_pkg;
  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  localparam logic [3:0]  RXS_ADDR_CAUSE  = 4'h0;
  localparam logic [3:0]  RXS_ADDR_CFG    = 4'h4;
  localparam logic [3:0]  RXS_ADDR_STAT   = 4'h8;
  localparam logic [3:0]  RXS_ADDR_IRQEN  = 4'hC;
  // ==========================================================
  // Cause register bit positions
  localparam int RXS_B_POR  = 7;
  localparam int RXS_B_PIN  = 6;
  localparam int RXS_B_WDG  = 5;
  localparam int RXS_B_OPC  = 4;
  localparam int RXS_B_FET  = 3;
  localparam int RXS_B_BRN  = 1;
  // Config register bit positions
  localparam int RXS_C_WDIS = 0;
  localparam int RXS_C_STOP = 1;
  localparam int RXS_C_SHRT = 2;
  localparam int RXS_C_BPO  = 3;
  localparam int RXS_C_BRO  = 4;
  localparam logic [4:0] RXS_CFG_RST = 5'h00;
  // ==========================================================
  // Timing counts in reference clock cycles
  localparam int RXS_LONG_CNT  = 4096;
  localparam int RXS_TAIL_CNT  = 64;
  localparam int RXS_SHORT_CNT = 32;
  localparam int RXS_CNT_W     = 12;
  localparam int RXS_NIRQ      = 8;
  localparam logic [1:0] RXS_RESP_OK  = 2'h0;
  localparam logic [1:0] RXS_RESP_ERR = 2'h2;

  typedef enum logic [4:0]
  {
    RXS_RUN   = 5'h01,
    RXS_LONG  = 5'h02,
    RXS_PINLO = 5'h04,
    RXS_TAIL  = 5'h08,
    RXS_STOP  = 5'h10
  } rxs_state_e;

  typedef struct packed
  {
    logic instr_done;
    logic bad_opcode;
    logic stop_exec;
    logic opcode_fetch;
    logic unmapped;
    logic mask_i;
    logic soft_trap;
    logic trap_return;
  } rxs_cpu_s;

  typedef struct packed
  {
    logic       take;
    logic       trap_vec;
    logic [2:0] vec_idx;
  } rxs_exc_s;
endpackage : rxs_pkg

// ==== rxs_cpu_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// CPU core stand-in: bench opcodes become one-cycle qualifiers
module rxs_cpu_model
  import rxs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] op,
  input  wire logic       go,
  input  wire rxs_exc_s   exc,
  input  wire logic       internal_reset,
  output rxs_cpu_s        cpu
);
  logic ret_r;

  // Return clears the mask a cycle before its boundary, as the pulled state lands first
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpu        <= '0;
      cpu.mask_i <= 1'b1;
      ret_r      <= 1'b0;
    end
    else
    begin
      ret_r            <= go && op == 3'd6;
      cpu.instr_done   <= (go && (op == 3'd0 || op == 3'd5)) || ret_r;
      cpu.bad_opcode   <= go && op == 3'd1;
      cpu.stop_exec    <= go && op == 3'd2;
      cpu.opcode_fetch <= go && op == 3'd3;
      cpu.unmapped     <= go && (op == 3'd3 || op == 3'd4);
      cpu.soft_trap    <= go && op == 3'd5;
      cpu.trap_return  <= go && op == 3'd6;
      if (internal_reset || exc.take)
        cpu.mask_i <= 1'b1;
      else if (go && op == 3'd6)
        cpu.mask_i <= 1'b0;
    end
  end
endmodule : rxs_cpu_model

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import rxs_pkg::*;
  localparam int LC = 64;
  typedef struct packed
  {
    logic [2:0]  op;
    logic [31:0] cfg;
    logic        bo;
    logic [31:0] cause;
    int          pin;
    int          tail;
  } rxs_row_s;
  // ==========================================================
  // Signals
  logic                clk_sys = 1'b0, rst = 1'b1, osc_ref_clock = 1'b0;
  logic                power_on_pulse = 1'b0, brownout = 1'b0, break_req = 1'b0;
  logic [RXS_NIRQ-1:0] irq_req = '0;
  logic [2:0]          op = 3'd0;
  logic                go = 1'b0, last_pc = 1'b0;
  rxs_cpu_s            cpu;
  rxs_exc_s            exc, last_exc;
  logic                internal_reset, pin_reset_out, pin_reset_oe, clock_gen_output;
  logic                cpu_clk_en, watchdog_tick, stack_pc_minus1, pin_reset_in_n;
  logic [3:0]          s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0]         s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp, ref_div = 2'd0;
  int                  ref_falls = 0, n_take = 0, n_mismatch = 0, n_compared = 0, f0, f1, f2;
  rxs_row_s            rows [8];

  // Pin has a pull-up, so a released line reads high
  assign pin_reset_in_n = pin_reset_oe ? pin_reset_out : 1'b1;

  rxs_top #(.LONG_CNT(LC)) dut (.clk_sys, .rst, .osc_ref_clock, .power_on_pulse, .brownout,
    .pin_reset_in_n, .break_req, .cpu, .irq_req, .internal_reset, .pin_reset_out, .pin_reset_oe,
    .clock_gen_output, .cpu_clk_en, .watchdog_tick, .exc, .stack_pc_minus1, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rxs_cpu_model cpu_m (.clk_sys, .rst, .op, .go, .exc, .internal_reset, .cpu);

  // ==========================================================
  // Clocks, reference divider and exception capture
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Reference runs at a quarter of the system clock, inside the sampler's reach
  always @(posedge clk_sys)
  begin
    ref_div <= ref_div + 2'd1;
    osc_ref_clock <= ref_div[1];
    if (osc_ref_clock && !ref_div[1])
      ref_falls <= ref_falls + 1;
    if (exc.take === 1'b1)
    begin
      n_take <= n_take + 1;
      last_exc <= exc;
      last_pc <= stack_pc_minus1;
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] near(input int got, input int exp);
    return {31'h0, got >= exp - 2 && got <= exp + 2};
  endfunction : near

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    chk({30'h0, s_axi_bresp}, {30'h0, RXS_RESP_OK}, "write response");
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, RXS_RESP_OK}, "read response");
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd

  task automatic cmd(input logic [2:0] c);
    repeat (2) @(posedge clk_sys);
    op <= c;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask : cmd

  // Times pin-low and tail phases in reference falls
  task automatic run_seq(input int pin, input int tail);
    int n;
    n = 0;
    while (pin_reset_oe !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (pin == 0)
    begin
      chk({31'h0, pin_reset_oe}, 32'h0, "unexpected reset");
      return;
    end
    f0 = ref_falls;
    if (pin == LC)
      chk({29'h0, cpu_clk_en, clock_gen_output, pin_reset_out}, 32'h2, "long hold outputs");
    while (pin_reset_oe === 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      n++;
    end
    f1 = ref_falls;
    while (internal_reset === 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      n++;
    end
    f2 = ref_falls;
    chk(near(f1 - f0, pin), 32'h1, "pin low length");
    chk(near(f2 - f1, tail), 32'h1, "tail length");
  endtask : run_seq

  task automatic exc_chk(input int cnt, input logic [5:0] e);
    chk(cnt, n_take, "exception count");
    chk({26'h0, last_exc.take, last_exc.trap_vec, last_exc.trap_vec ? 3'd0 : last_exc.vec_idx,
      last_pc}, {26'h0, e}, "exception kind");
  endtask : exc_chk

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Watchdog: the whole run, prescaler wrap included, needs about 20000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    $display("[ERR] %0t run did not complete", $time);
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rows[0] = '{3'd7, 32'h00, 1'b0, 32'h80, LC, 64};
    rows[1] = '{3'd1, 32'h00, 1'b0, 32'h10, 32, 32};
    rows[2] = '{3'd2, 32'h00, 1'b0, 32'h10, 32, 32};
    rows[3] = '{3'd3, 32'h00, 1'b0, 32'h08, 32, 32};
    rows[4] = '{3'd4, 32'h00, 1'b0, 32'h00, 0, 0};
    rows[5] = '{3'd0, 32'h00, 1'b1, 32'h02, LC, 64};
    rows[6] = '{3'd0, 32'h08, 1'b1, 32'h00, 0, 0};
    rows[7] = '{3'd0, 32'h10, 1'b1, 32'h00, 0, 0};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    run_seq(LC, 64);
    axi_rd(RXS_ADDR_CAUSE, rd);
    axi_rd(RXS_ADDR_CFG, rd);
    chk(rd, {27'h0, RXS_CFG_RST}, "config reset value");
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(RXS_ADDR_CFG, rows[i].cfg);
      if (rows[i].op == 3'd7)
      begin
        power_on_pulse <= 1'b1;
        @(posedge clk_sys);
        power_on_pulse <= 1'b0;
      end
      else if (rows[i].bo)
      begin
        brownout <= 1'b1;
        repeat (20) @(posedge clk_sys);
        brownout <= 1'b0;
      end
      else
        cmd(rows[i].op);
      run_seq(rows[i].pin, rows[i].tail);
      axi_rd(RXS_ADDR_CAUSE, rd);
      chk(rd, rows[i].cause, "cause flags");
      axi_rd(RXS_ADDR_CAUSE, rd);
      chk(rd, 32'h0, "cause after read");
      $display("row %0d done", i);
    end
    // Bit 1 is higher priority but disabled, so bit 2 must win
    axi_wr(RXS_ADDR_IRQEN, 32'h0C);
    cmd(3'd6);
    irq_req <= 8'h0E;
    cmd(3'd0);
    exc_chk(1, 6'b10_010_1);
    cmd(3'd0);
    exc_chk(1, 6'b10_010_1);
    irq_req <= 8'h0A;
    cmd(3'd6);
    exc_chk(2, 6'b10_011_1);
    cmd(3'd5);
    exc_chk(3, 6'b11_000_0);
    irq_req <= 8'h00;
    break_req <= 1'b1;
    cmd(3'd0);
    exc_chk(4, 6'b11_000_0);
    break_req <= 1'b0;
    $display("exception test done");
    axi_wr(RXS_ADDR_CFG, 32'h06);
    cmd(3'd2);
    chk({31'h0, cpu_clk_en}, 32'h0, "clocks in stop");
    irq_req <= 8'h08;
    f0 = ref_falls;
    for (int n = 0; n < 2000 && cpu_clk_en !== 1'b1; n++)
      @(posedge clk_sys);
    chk(near(ref_falls - f0, RXS_SHORT_CNT), 32'h1, "short wake length");
    irq_req <= 8'h00;
    $display("stop test done");
    // Counter restarted from zero at wake, so the prescaler wraps a full span later
    for (int n = 0; n < 20000 && watchdog_tick !== 1'b1; n++)
      @(posedge clk_sys);
    chk(near(ref_falls - f0, RXS_LONG_CNT), 32'h1, "prescaler wrap");
    $display("prescaler test done");
    tally_and_finish();
  end
endmodule : tb
